// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst, autoStart, cfgWrite, startCount, refresh;
  logic        cfgResetSel, cfgHaltSleep, sleepMode, clrUnderflow;
  logic        clrRefreshErr, underflowFlag, refreshErrFlag, counting;
  logic        nmiReq, resetReq;
  logic [2:0]  cfgTimeout;
  logic [3:0]  cfgDivider;
  logic [1:0]  cfgWinStart, cfgWinEnd;
  logic [14:0] counterValue, timeoutTicks;
  logic [13:0] divRatio;
  logic [31:0] seed;
  int          fails, checksDone, cycles, nmiSeen, i, w, n, rem, a, b;
  wwdt_core i_dut (.ref_clk, .rst, .autoStart, .cfgWrite, .cfgTimeout,
    .cfgDivider, .cfgWinStart, .cfgWinEnd, .cfgResetSel, .cfgHaltSleep,
    .startCount, .refresh, .sleepMode, .clrUnderflow, .clrRefreshErr,
    .underflowFlag, .refreshErrFlag, .counterValue, .divRatio,
    .timeoutTicks, .counting, .nmiReq, .resetReq);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (nmiReq === 1'b1) nmiSeen++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [14:0] expTo(input int s);
    return (s == 0) ? 15'h0080 : 15'h0100 << s;
  endfunction : expTo
  function automatic logic [14:0] expDiv(input int s);
    return s < 3 ? 15'h0001 << 2 * s : 15'h0001 << (s < 8 ? s + 2 : 2 * s - 5);
  endfunction : expDiv
  function automatic logic expWin(input int r, ws, we);
    return r <= 32 * (3 - ws) && r >= 32 * (3 - we);
  endfunction : expWin
  function automatic int nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 100);
  endfunction : nextRand
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic chkVal(input logic [14:0] got, exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chkVal
  task automatic chkBit(input logic got, exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkBit
  task automatic runCfg(input int to, dv, ws, we, input logic rs, hs);
    rst = 1;
    cfgTimeout = 3'(to);
    cfgDivider = 4'(dv);
    cfgWinStart = 2'(ws);
    cfgWinEnd = 2'(we);
    cfgResetSel = rs;
    cfgHaltSleep = hs;
    cyc(2);
    rst = 0;
    cyc(1);
    cfgWrite = 1;
    cyc(1);
    cfgWrite = 0;
    startCount = 1;
    cyc(1);
    startCount = 0;
  endtask : runCfg
  task automatic give_verdict();
    if (fails == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1;
    {autoStart, cfgWrite, startCount, refresh, cfgResetSel, cfgHaltSleep,
     sleepMode, clrUnderflow, clrRefreshErr, cfgTimeout, cfgDivider,
     cfgWinStart, cfgWinEnd} = '0;
    seed = 32'h0000_5337;
    cyc(2);
    chkVal({1'b0, divRatio}, 15'h2000);
    chkVal(timeoutTicks, 15'h4000);
    for (i = 0; i < 10; i++) begin
      runCfg(i % 7, i, 0, 3, 1'b0, 1'b0);
      chkVal({1'b0, divRatio}, expDiv(i));
      chkVal(timeoutTicks, expTo(i % 7));
      chkVal(counterValue, expTo(i % 7) - 1'b1);
      cfgTimeout = 3'((i + 1) % 7);
      cfgWrite = 1;
      cyc(1);
      cfgWrite = 0;
      chkVal(timeoutTicks, expTo(i % 7));
    end
    for (i = 0; i < 40; i++) begin
      a = i % 4;
      b = (i / 4) % 4;
      runCfg(0, 0, a, b, 1'b0, 1'b0);
      case ((i / 2) % 4)
        0: w = 127 - 32 * (3 - b);
        1: w = 128 - 32 * (3 - b);
        2: w = 127 - 32 * (3 - a);
        default: w = nextRand();
      endcase
      if (w > 100) w = 100;
      cyc(w);
      rem = counterValue;
      nmiSeen = 0;
      refresh = 1;
      cyc(1);
      refresh = 0;
      if (expWin(rem, a, b)) begin
        chkVal(counterValue, 15'h007F);
        chkBit(refreshErrFlag, 1'b0);
      end else begin
        chkBit(refreshErrFlag, 1'b1);
        chkBit(underflowFlag, 1'b0);
      end
      cyc(2);
      chkVal(15'(nmiSeen), expWin(rem, a, b) ? 15'h0000 : 15'h0001);
    end
    runCfg(0, 0, 0, 3, 1'b0, 1'b0);
    refresh = 1;
    cyc(1);
    refresh = 0;
    nmiSeen = 0;
    for (n = 0; n < 300 && underflowFlag !== 1'b1; n++) cyc(1);
    cyc(2);
    chkBit(underflowFlag, 1'b1);
    chkBit(refreshErrFlag, 1'b1);
    chkVal(15'(nmiSeen), 15'h0002);
    chkBit(resetReq, 1'b0);
    clrUnderflow = 1;
    cyc(1);
    clrUnderflow = 0;
    chkBit(underflowFlag, 1'b0);
    chkBit(refreshErrFlag, 1'b1);
    clrRefreshErr = 1;
    cyc(1);
    clrRefreshErr = 0;
    chkBit(refreshErrFlag, 1'b0);
    runCfg(0, 0, 0, 3, 1'b1, 1'b0);
    nmiSeen = 0;
    for (n = 0; n < 300 && resetReq !== 1'b1; n++) cyc(1);
    cyc(20);
    chkBit(resetReq, 1'b1);
    chkBit(underflowFlag, 1'b1);
    chkVal(15'(nmiSeen), 15'h0000);
    for (i = 1; i >= 0; i--) begin
      runCfg(0, 0, 0, 3, 1'b0, i[0]);
      sleepMode = 1;
      cyc(1);
      rem = counterValue;
      cyc(20);
      chkVal(counterValue, 15'(i ? rem : rem - 20));
      sleepMode = 0;
    end
    rst = 1;
    autoStart = 1;
    cyc(2);
    rst = 0;
    cyc(2);
    chkBit(counting, 1'b1);
    chkVal(counterValue, 15'h3FFF);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ===== wwdt_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_regs.svh"
module wwdt_core
  import wwdt_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       autoStart,
  input  wire logic                       cfgWrite,
  input  wire logic [`WWDT_TO_SEL_W-1:0]  cfgTimeout,
  input  wire logic [`WWDT_DIV_SEL_W-1:0] cfgDivider,
  input  wire logic [`WWDT_WIN_SEL_W-1:0] cfgWinStart,
  input  wire logic [`WWDT_WIN_SEL_W-1:0] cfgWinEnd,
  input  wire logic                       cfgResetSel,
  input  wire logic                       cfgHaltSleep,
  input  wire logic                       startCount,
  input  wire logic                       refresh,
  input  wire logic                       sleepMode,
  input  wire logic                       clrUnderflow,
  input  wire logic                       clrRefreshErr,
  output logic                            underflowFlag,
  output logic                            refreshErrFlag,
  output logic      [`WWDT_CNT_W-1:0]     counterValue,
  output logic      [`WWDT_DIV_W:0]       divRatio,
  output logic      [`WWDT_CNT_W-1:0]     timeoutTicks,
  output logic                            counting,
  output logic                            nmiReq,
  output logic                            resetReq
);
  wwdt_state_t                 state_reg;
  wwdt_state_t                 state_next;
  logic [`WWDT_TO_SEL_W-1:0]   toSel_reg;
  logic [`WWDT_DIV_SEL_W-1:0]  divSel_reg;
  logic [`WWDT_WIN_SEL_W-1:0]  wsSel_reg;
  logic [`WWDT_WIN_SEL_W-1:0]  weSel_reg;
  logic                        rstSel_reg;
  logic                        haltSel_reg;
  logic                        cfgLocked_reg;
  logic                        autoDone_reg;
  logic [`WWDT_CNT_W-1:0]      cnt_reg;
  logic [`WWDT_CNT_W-1:0]      cnt_next;
  logic                        unf_reg;
  logic                        rfe_reg;
  logic                        nmi_reg;
  logic                        rreq_reg;
  logic [`WWDT_CNT_W-1:0]      period;
  logic [`WWDT_CNT_W-1:0]      winHigh;
  logic [`WWDT_CNT_W-1:0]      winLow;
  logic                        run;
  logic                        tick;
  logic                        inWindow;
  logic                        goodRefresh;
  logic                        badRefresh;
  logic                        underflow;
  logic                        errEvent;
  logic                        restart;

  always_comb begin
    unique case (toSel_reg)
      3'h0:    period = `WWDT_TO_128;
      3'h1:    period = `WWDT_TO_512;
      3'h2:    period = `WWDT_TO_1024;
      3'h3:    period = `WWDT_TO_2048;
      3'h4:    period = `WWDT_TO_4096;
      3'h5:    period = `WWDT_TO_8192;
      default: period = `WWDT_TO_16384;
    endcase
  end

  always_comb begin
    unique case (wsSel_reg)
      2'h0: winHigh = period - (period >> 2);
      2'h1: winHigh = period >> 1;
      2'h2: winHigh = period >> 2;
      2'h3: winHigh = '0;
    endcase
  end

  always_comb begin
    unique case (weSel_reg)
      2'h0: winLow = period - (period >> 2);
      2'h1: winLow = period >> 1;
      2'h2: winLow = period >> 2;
      2'h3: winLow = '0;
    endcase
  end

  // Start percent counts elapsed; remaining count must be at or below it
  assign inWindow = (cnt_reg <= winHigh) && (cnt_reg >= winLow)
                    && (winHigh != '0 || cnt_reg == '0);
  assign counting    = (state_reg == WWDT_RUN);
  assign run         = counting && !(haltSel_reg && sleepMode);
  assign goodRefresh = counting && refresh && inWindow;
  assign badRefresh  = counting && refresh && !inWindow;
  assign underflow   = run && tick && (cnt_reg == '0) && !refresh;
  assign errEvent    = underflow || badRefresh;
  assign restart     = goodRefresh || errEvent || (state_reg != WWDT_RUN);

  wwdt_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (run),
    .restart (restart),
    .divSel  (divSel_reg),
    .tick    (tick),
    .ratio   (divRatio)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      toSel_reg     <= `WWDT_AUTO_TO;
      divSel_reg    <= `WWDT_AUTO_DIV;
      wsSel_reg     <= `WWDT_AUTO_WS;
      weSel_reg     <= `WWDT_AUTO_WE;
      rstSel_reg    <= `WWDT_AUTO_RST;
      haltSel_reg   <= `WWDT_AUTO_HALT;
      cfgLocked_reg <= 1'b0;
    end else if (cfgWrite && !cfgLocked_reg && state_reg == WWDT_IDLE) begin
      toSel_reg     <= cfgTimeout;
      divSel_reg    <= cfgDivider;
      wsSel_reg     <= cfgWinStart;
      weSel_reg     <= cfgWinEnd;
      rstSel_reg    <= cfgResetSel;
      haltSel_reg   <= cfgHaltSleep;
      cfgLocked_reg <= 1'b1;
    end
  end

  // Strap sampled once after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      autoDone_reg <= 1'b0;
    end else begin
      autoDone_reg <= 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WWDT_IDLE: begin
        if ((!autoDone_reg && autoStart) || startCount) begin
          state_next = WWDT_RUN;
        end
      end
      WWDT_RUN: begin
        if (errEvent && rstSel_reg) begin
          state_next = WWDT_HALT;
        end
      end
      WWDT_HALT: state_next = WWDT_HALT;
      default:   state_next = WWDT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= WWDT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (state_reg != WWDT_RUN || goodRefresh || errEvent) begin
      cnt_next = period - 15'h0001;
    end else if (run && tick) begin
      cnt_next = cnt_reg - 15'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unf_reg <= 1'b0;
    end else if (underflow) begin
      unf_reg <= 1'b1;
    end else if (clrUnderflow) begin
      unf_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rfe_reg <= 1'b0;
    end else if (badRefresh) begin
      rfe_reg <= 1'b1;
    end else if (clrRefreshErr) begin
      rfe_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nmi_reg  <= 1'b0;
      rreq_reg <= 1'b0;
    end else begin
      nmi_reg  <= errEvent && !rstSel_reg;
      rreq_reg <= rreq_reg || (errEvent && rstSel_reg);
    end
  end

  assign underflowFlag  = unf_reg;
  assign refreshErrFlag = rfe_reg;
  assign counterValue   = cnt_reg;
  assign timeoutTicks   = period;
  assign nmiReq         = nmi_reg;
  assign resetReq       = rreq_reg;
endmodule : wwdt_core
`default_nettype wire

// ===== wwdt_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_regs.svh"
module wwdt_core_chk (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   startCount,
  input wire logic                   refresh,
  input wire logic                   sleepMode,
  input wire logic                   cfgHaltSleep,
  input wire logic                   clrUnderflow,
  input wire logic                   underflowFlag,
  input wire logic [`WWDT_CNT_W-1:0] counterValue,
  input wire logic [`WWDT_DIV_W:0]   divRatio,
  input wire logic [`WWDT_CNT_W-1:0] timeoutTicks,
  input wire logic                   counting,
  input wire logic                   nmiReq,
  input wire logic                   resetReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_NMI_PULSE: assert property (nmiReq |=> !nmiReq)
    else $error("nmi pulse too long");
  AST_RST_HOLD: assert property (resetReq |=> resetReq)
    else $error("reset request dropped");
  AST_UF_HOLD: assert property (underflowFlag && !clrUnderflow |=>
    underflowFlag) else $error("underflow flag lost");
  AST_UF_CLR: assert property (clrUnderflow && counterValue != 0 |=>
    !underflowFlag) else $error("underflow flag not cleared");
  AST_START: assert property (startCount && !counting && !resetReq |=>
    counting && counterValue == $past(timeoutTicks) - 1'b1)
    else $error("start load wrong");
  AST_DIV1: assert property (counting && divRatio == 1
    && !sleepMode && !refresh && !resetReq && counterValue != 0 |=>
    counterValue == $past(counterValue) - 1'b1) else $error("no decrement");
  AST_SLEEP: assert property ((counting && cfgHaltSleep
    && sleepMode && !refresh)[*2] |=> $stable(counterValue))
    else $error("count in sleep");
  AST_UF_REQ: assert property ($rose(underflowFlag) |-> ##[0:1]
    (nmiReq || resetReq)) else $error("no request on underflow");
  cover property (nmiReq);
  cover property (resetReq);
  cover property (underflowFlag && counting && sleepMode);
endmodule : wwdt_core_chk
bind wwdt_core wwdt_core_chk i_chk (.ref_clk, .rst, .startCount, .refresh,
  .sleepMode, .cfgHaltSleep, .clrUnderflow, .underflowFlag, .counterValue,
  .divRatio, .timeoutTicks, .counting, .nmiReq, .resetReq);
`default_nettype wire

// ===== wwdt_pkg.sv
package wwdt_pkg;
  typedef enum logic [2:0] {
    WWDT_IDLE = 3'b001,
    WWDT_RUN  = 3'b010,
    WWDT_HALT = 3'b100
  } wwdt_state_t;
endpackage : wwdt_pkg

// ===== wwdt_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_regs.svh"
module wwdt_prescaler (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       run,
  input  wire logic                       restart,
  input  wire logic [`WWDT_DIV_SEL_W-1:0] divSel,
  output logic                            tick,
  output logic      [`WWDT_DIV_W:0]       ratio
);
  logic [`WWDT_DIV_W-1:0] preCnt_reg;
  logic [`WWDT_DIV_W-1:0] preCnt_next;
  always_comb begin
    unique case (divSel)
      4'h0:    ratio = `WWDT_DIV_1;
      4'h1:    ratio = `WWDT_DIV_4;
      4'h2:    ratio = `WWDT_DIV_16;
      4'h3:    ratio = `WWDT_DIV_32;
      4'h4:    ratio = `WWDT_DIV_64;
      4'h5:    ratio = `WWDT_DIV_128;
      4'h6:    ratio = `WWDT_DIV_256;
      4'h7:    ratio = `WWDT_DIV_512;
      4'h8:    ratio = `WWDT_DIV_2048;
      default: ratio = `WWDT_DIV_8192;
    endcase
  end
  assign tick = run && ({1'b0, preCnt_reg} == ratio - 14'h0001);
  always_comb begin
    preCnt_next = preCnt_reg;
    if (restart || tick) begin
      preCnt_next = '0;
    end else if (run) begin
      preCnt_next = preCnt_reg + 13'h0001;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preCnt_reg <= '0;
    end else begin
      preCnt_reg <= preCnt_next;
    end
  end
endmodule : wwdt_prescaler
`default_nettype wire

// ===== wwdt_regs.svh
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH
`define WWDT_CNT_W      15
`define WWDT_DIV_W      13
`define WWDT_TO_SEL_W   3
`define WWDT_DIV_SEL_W  4
`define WWDT_WIN_SEL_W  2
`define WWDT_TO_128     15'h0080
`define WWDT_TO_512     15'h0200
`define WWDT_TO_1024    15'h0400
`define WWDT_TO_2048    15'h0800
`define WWDT_TO_4096    15'h1000
`define WWDT_TO_8192    15'h2000
`define WWDT_TO_16384   15'h4000
`define WWDT_DIV_1      14'h0001
`define WWDT_DIV_4      14'h0004
`define WWDT_DIV_16     14'h0010
`define WWDT_DIV_32     14'h0020
`define WWDT_DIV_64     14'h0040
`define WWDT_DIV_128    14'h0080
`define WWDT_DIV_256    14'h0100
`define WWDT_DIV_512    14'h0200
`define WWDT_DIV_2048   14'h0800
`define WWDT_DIV_8192   14'h2000
`define WWDT_AUTO_TO    3'h6
`define WWDT_AUTO_DIV   4'h9
`define WWDT_AUTO_WS    2'h3
`define WWDT_AUTO_WE    2'h3
`define WWDT_AUTO_RST   1'b1
`define WWDT_AUTO_HALT  1'b0
`endif
